// File: hdl/motor_diag_pkg.sv
// Constants, types and helpers for the diagnostic readback bank.
// Assumes one core clock at 25 MHz and a serial link on its own clock.
//
// Notes on behaviour
// - Fault word shows temperature, current, six lock flags
// - Speed refreshed from phase U crossing interval
// - Speed register is hertz times ten
// - Period register counts 10 us units
// - Back-EMF integral per half cycle, once per cycle
// - Constant register is volts per hertz times 2180
// - Detected rotor sector stored after position sensing
// - Position equals sector code plus advance, mod 256
// - Supply sampled while running, 30 V full scale
// - Active speed input becomes one command value
// - Command follows PWM, analog or serial source
// - Applied duty reported apart from command
// - Readback is a snapshot taken at index write, no capture request
// - Target answers at seven-bit address 0x52
// - Read: index write, repeated start, two bytes
// - Seven read-write control words at 0x30-0x36
// - Nine read-only status words at 0x00-0x08
// - Seven parameter words at 0x90-0x96
package motor_diag_pkg;

  // Target address and register indices
  localparam logic [6:0] DEV_ADDR   = 7'h52;
  localparam logic [7:0] REG_FAULT  = 8'h00;
  localparam logic [7:0] REG_SPEED  = 8'h01;
  localparam logic [7:0] REG_PERIOD = 8'h02;
  localparam logic [7:0] REG_KT     = 8'h03;
  localparam logic [7:0] REG_CURR   = 8'h04;
  localparam logic [7:0] REG_POSSUP = 8'h05;
  localparam logic [7:0] REG_CMD    = 8'h06;
  localparam logic [7:0] REG_ANALOG = 8'h07;
  localparam logic [7:0] REG_IDS    = 8'h08;
  localparam logic [7:0] CTRL_FIRST = 8'h30;
  localparam logic [7:0] CTRL_LAST  = 8'h36;
  localparam logic [7:0] EE_FIRST   = 8'h90;
  localparam logic [7:0] EE_LAST    = 8'h96;
  localparam int         NUM_WORDS  = 7;

  // Fault word bit positions
  localparam int FB_OVER_TEMP = 15;
  localparam int FB_OVER_CURR = 11;
  localparam int FB_LOCK_LO   = 0;

  // Timing: period unit and core clock
  localparam int CLK_NS    = 40;
  localparam int TICK_NS   = 10000;
  localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [19:0] SPEED_NUM = 20'hF4240;
  localparam logic [3:0]  BIT_LAST  = 4'h7;
  localparam logic [3:0]  BIT_ACK   = 4'h8;

  // Speed source selection
  typedef enum logic [1:0] {
    SRC_PWM    = 2'h0,
    SRC_ANALOG = 2'h1,
    SRC_SERIAL = 2'h3
  } cmd_src_t;

  // Link states, Gray from L_IDLE through L_WLO on the write path
  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_ADDR = 3'h1,
    L_REG  = 3'h3,
    L_WHI  = 3'h2,
    L_WLO  = 3'h6,
    L_READ = 3'h7
  } link_state_t;

  typedef enum logic {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} div_state_t;

  // Rotor sector code plus advance code, wrapping at 256
  function automatic logic [7:0] ipd_code(input logic [2:0] sec,
                                          input logic [1:0] adv);
    logic [7:0] p;
    logic [7:0] a;
    unique case (sec)
      3'h0: p = 8'h00;
      3'h1: p = 8'h2B;
      3'h2: p = 8'h55;
      3'h3: p = 8'h80;
      3'h4: p = 8'hAB;
      default: p = 8'hD5;
    endcase
    unique case (adv)
      2'h0: a = 8'h16;
      2'h1: a = 8'h2C;
      2'h2: a = 8'h3F;
      default: a = 8'h55;
    endcase
    return p + a;
  endfunction

endpackage

// File: hdl/serial_target_link.sv
// Two-wire target engine running on the serial clock.
// Assumes an open-drain data line and a core that answers snapshots.
module serial_target_link
  import motor_diag_pkg::*;
(
  // Reset, asynchronous into this domain
  input  wire logic        rst,
  // Serial pins
  input  wire logic        sclClk,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Toward the core domain
  output logic [7:0]       regIdx,
  output logic [15:0]      wrWord,
  output logic             wrToggle,
  output logic             snapToggle,
  input  wire logic [15:0] snapWord
);

  typedef struct packed {
    link_state_t st;
    logic [3:0]  bitCnt;
    logic [6:0]  shift;
    logic        ackOwn;
    logic        startSeen;
    logic [7:0]  idx;
    logic [7:0]  wrHi;
    logic [15:0] wrWord;
    logic        wrTog;
    logic        snapTog;
    logic [7:0]  tx;
  } link_t;

  link_t      cur_ff;
  link_t      nxt_ff;
  logic       startTog_ff;
  logic       drive_ff;
  logic [7:0] byteV;

  ////////////////////////////////////////////////////////////////////
  // Start condition: data falls while clock high
  always_ff @(negedge sdaIn or posedge rst) begin
    if (rst) begin
      startTog_ff <= 1'b0;
    end else if (sclClk) begin
      startTog_ff <= ~startTog_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bit sampling and byte decode on rising clock
  always_comb begin
    nxt_ff = cur_ff;
    byteV  = {cur_ff.shift, sdaIn};
    if (startTog_ff != cur_ff.startSeen) begin
      nxt_ff.startSeen = startTog_ff;
      nxt_ff.st        = L_ADDR;
      nxt_ff.bitCnt    = 4'h1;
      nxt_ff.shift     = {6'h00, sdaIn};
      nxt_ff.ackOwn    = 1'b0;
    end else if (cur_ff.bitCnt == BIT_ACK) begin
      nxt_ff.bitCnt = 4'h0;
      nxt_ff.ackOwn = 1'b0;
      // Host acknowledge of a sent byte
      if (cur_ff.st == L_READ && !cur_ff.ackOwn) begin
        if (sdaIn) begin
          nxt_ff.st = L_IDLE;
        end else begin
          nxt_ff.tx = snapWord[7:0];
        end
      end
    end else begin
      nxt_ff.shift  = byteV[6:0];
      nxt_ff.bitCnt = cur_ff.bitCnt + 4'h1;
      if (cur_ff.bitCnt == BIT_LAST) begin
        unique case (cur_ff.st)
          L_ADDR: begin
            if (byteV[7:1] == DEV_ADDR) begin
              nxt_ff.ackOwn = 1'b1;
              nxt_ff.st     = byteV[0] ? L_READ : L_REG;
              nxt_ff.tx     = snapWord[15:8];
            end else begin
              nxt_ff.st = L_IDLE;
            end
          end
          L_REG: begin
            nxt_ff.idx     = byteV;
            nxt_ff.snapTog = ~cur_ff.snapTog;
            nxt_ff.ackOwn  = 1'b1;
            nxt_ff.st      = L_WHI;
          end
          L_WHI: begin
            nxt_ff.wrHi   = byteV;
            nxt_ff.ackOwn = 1'b1;
            nxt_ff.st     = L_WLO;
          end
          L_WLO: begin
            nxt_ff.wrWord = {cur_ff.wrHi, byteV};
            nxt_ff.wrTog  = ~cur_ff.wrTog;
            nxt_ff.ackOwn = 1'b1;
            nxt_ff.st     = L_IDLE;
          end
          L_READ, L_IDLE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge sclClk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Line drive changes on falling clock: ack or data zero
  always_ff @(negedge sclClk or posedge rst) begin
    if (rst) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= (cur_ff.bitCnt == BIT_ACK && cur_ff.ackOwn)
        || (cur_ff.st == L_READ && !cur_ff.bitCnt[3]
            && !cur_ff.tx[~cur_ff.bitCnt[2:0]]);
    end
  end

  // Open drain: only ever pulls low
  assign sdaOut     = 1'b0;
  assign sdaOe      = drive_ff;
  assign regIdx     = cur_ff.idx;
  assign wrWord     = cur_ff.wrWord;
  assign wrToggle   = cur_ff.wrTog;
  assign snapToggle = cur_ff.snapTog;

endmodule

// File: hdl/motor_diag_readback.sv
// Diagnostic readback bank with control and parameter storage.
// Assumes status inputs come from logic on clk; serial pins are async.
module motor_diag_readback
  import motor_diag_pkg::*;
#(
  parameter int          KT_SHIFT = 0,
  parameter logic [15:0] ID_WORD  = 16'h0101 // Arbitrary identity
)
(
  // Core clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Serial link
  input  wire logic             sclClk,
  input  wire logic             sdaIn,
  output logic                  sdaOut,
  output logic                  sdaOe,
  // Fault sources
  input  wire logic             over_temperature_flag,
  input  wire logic             overCurrent,
  input  wire logic [5:0]       lockedRotor,
  // Rotation measurements
  input  wire logic             spinning,
  input  wire logic             zeroCross,
  input  wire logic             halfCross,
  input  wire logic [7:0]       bemfLevel,
  input  wire logic [10:0]      motorCurrent,
  // Position sensing result
  input  wire logic             ipdDone,
  input  wire logic [2:0]       ipdSector,
  input  wire logic [1:0]       ipdAdvance,
  // Supply and speed sources
  input  wire logic             supplySample,
  input  wire logic [7:0]       supplyAdc,
  input  wire logic [1:0]       cmdMode,
  input  wire logic [7:0]       pwmDuty,
  input  wire logic [9:0]       analogLevel,
  input  wire logic [7:0]       appliedDuty,
  // Stored words and command toward the drive
  output logic [6:0][15:0]      ctrlWords,
  output logic [6:0][15:0]      eeWords,
  output logic [7:0]            commandedSpeed
);

  initial begin
    if (KT_SHIFT < 0 || KT_SHIFT > 8) begin
      $error("KT_SHIFT out of range");
    end
  end

  typedef struct packed {
    logic [2:0]       wrSync;
    logic [2:0]       snapSync;
    logic [15:0]      snap;
    logic [6:0][15:0] ctrl;
    logic [6:0][15:0] ee;
    logic [15:0]      fault;
    logic [7:0]       tick;
    logic [15:0]      pcnt;
    logic [15:0]      period;
    logic [15:0]      speed;
    div_state_t       divSt;
    logic [4:0]       divBit;
    logic [16:0]      rem;
    logic [19:0]      quo;
    logic [15:0]      dvsr;
    logic             halfOn;
    logic [23:0]      acc;
    logic [15:0]      kt;
    logic [7:0]       inductive_position_detect;
    logic [7:0]       supply;
    logic [7:0]       cmd;
    logic [7:0]       applied;
    logic [9:0]       analog;
    logic [10:0]      current;
  } core_t;

  core_t       cur_ff;
  core_t       nxt_ff;
  logic [7:0]  regIdx;
  logic [15:0] wrWord;
  logic        wrToggle;
  logic        snapToggle;
  logic        wrEvent;
  logic        snapEvent;
  logic        tickHit;
  logic [16:0] trial;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Word seen by the host at a given index
  function automatic logic [15:0] read_word(input core_t s,
                                            input logic [7:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    if (idx >= CTRL_FIRST && idx <= CTRL_LAST) begin
      w = s.ctrl[3'(idx - CTRL_FIRST)];
    end else if (idx >= EE_FIRST && idx <= EE_LAST) begin
      w = s.ee[3'(idx - EE_FIRST)];
    end else begin
      unique case (idx)
        REG_FAULT:  w = s.fault;
        REG_SPEED:  w = s.speed;
        REG_PERIOD: w = s.period;
        REG_KT:     w = s.kt;
        REG_CURR:   w = {5'h00, s.current};
        REG_POSSUP: w = {s.inductive_position_detect, s.supply};
        REG_CMD:    w = {s.cmd, s.applied};
        REG_ANALOG: w = {6'h00, s.analog};
        REG_IDS:    w = ID_WORD;
        default:    w = 16'h0000;
      endcase
    end
    return w;
  endfunction

  // Integral scaled and clipped to sixteen bits
  function automatic logic [15:0] kt_scale(input logic [23:0] a);
    logic [23:0] v;
    v = a >> KT_SHIFT;
    return (v[23:16] != 8'h00) ? 16'hFFFF : v[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Serial engine on the link clock
  serial_target_link u_link (
    .rst        (rst),
    .sclClk     (sclClk),
    .sdaIn      (sdaIn),
    .sdaOut     (sdaOut),
    .sdaOe      (sdaOe),
    .regIdx     (regIdx),
    .wrWord     (wrWord),
    .wrToggle   (wrToggle),
    .snapToggle (snapToggle),
    .snapWord   (cur_ff.snap)
  );

  // Events recovered from synchronised toggles
  assign wrEvent   = cur_ff.wrSync[2] ^ cur_ff.wrSync[1];
  assign snapEvent = cur_ff.snapSync[2] ^ cur_ff.snapSync[1];
  assign tickHit   = (cur_ff.tick == 8'(TICK_CYC - 1));
  assign trial     = {cur_ff.rem[15:0], cur_ff.quo[19]} - {1'b0, cur_ff.dvsr};

  ////////////////////////////////////////////////////////////////////
  // Next state of the whole bank
  always_comb begin
    nxt_ff = cur_ff;

    // Toggle synchronisers
    nxt_ff.wrSync   = {cur_ff.wrSync[1:0], wrToggle};
    nxt_ff.snapSync = {cur_ff.snapSync[1:0], snapToggle};

    // Snapshot of the indexed word for the link
    if (snapEvent) begin
      nxt_ff.snap = read_word(cur_ff, regIdx);
    end

    // Host writes; status indices ignore them
    if (wrEvent) begin
      if (regIdx >= CTRL_FIRST && regIdx <= CTRL_LAST) begin
        nxt_ff.ctrl[3'(regIdx - CTRL_FIRST)] = wrWord;
      end else if (regIdx >= EE_FIRST && regIdx <= EE_LAST) begin
        nxt_ff.ee[3'(regIdx - EE_FIRST)] = wrWord;
      end
    end

    // Live fault word
    nxt_ff.fault = 16'h0000;
    nxt_ff.fault[FB_OVER_TEMP] = over_temperature_flag;
    nxt_ff.fault[FB_OVER_CURR] = overCurrent;
    nxt_ff.fault[FB_LOCK_LO +: 6] = lockedRotor;

    // Ten microsecond tick
    nxt_ff.tick = tickHit ? 8'h00 : cur_ff.tick + 8'h01;

    // Period counter between phase U crossings
    if (!spinning) begin
      nxt_ff.pcnt = 16'h0000;
    end else if (zeroCross) begin
      nxt_ff.pcnt   = 16'h0000;
      nxt_ff.period = cur_ff.pcnt;
    end else if (tickHit && cur_ff.pcnt != 16'hFFFF) begin
      nxt_ff.pcnt = cur_ff.pcnt + 16'h0001;
    end

    // Speed as a million over period, by long division
    unique case (cur_ff.divSt)
      DIV_IDLE: begin
        if (spinning && zeroCross) begin
          if (cur_ff.pcnt < 16'h0010) begin
            nxt_ff.speed = 16'hFFFF;
          end else begin
            nxt_ff.divSt  = DIV_RUN;
            nxt_ff.dvsr   = cur_ff.pcnt;
            nxt_ff.quo    = SPEED_NUM;
            nxt_ff.rem    = 17'h00000;
            nxt_ff.divBit = 5'h13;
          end
        end
      end
      DIV_RUN: begin
        if (!trial[16]) begin
          nxt_ff.rem = trial;
          nxt_ff.quo = {cur_ff.quo[18:0], 1'b1};
        end else begin
          nxt_ff.rem = {cur_ff.rem[15:0], cur_ff.quo[19]};
          nxt_ff.quo = {cur_ff.quo[18:0], 1'b0};
        end
        nxt_ff.divBit = cur_ff.divBit - 5'h01;
        if (cur_ff.divBit == 5'h00) begin
          nxt_ff.divSt = DIV_IDLE;
          nxt_ff.speed = nxt_ff.quo[15:0];
        end
      end
    endcase

    // Back-EMF integral over the first half cycle
    if (!spinning) begin
      nxt_ff.halfOn = 1'b0;
      nxt_ff.acc    = 24'h000000;
    end else if (zeroCross) begin
      nxt_ff.halfOn = 1'b1;
      nxt_ff.acc    = 24'h000000;
    end else if (cur_ff.halfOn && halfCross) begin
      nxt_ff.halfOn = 1'b0;
      nxt_ff.kt     = kt_scale(cur_ff.acc);
    end else if (cur_ff.halfOn && tickHit) begin
      nxt_ff.acc = cur_ff.acc + {16'h0000, bemfLevel};
    end

    // Detected rotor position
    if (ipdDone) begin
      nxt_ff.inductive_position_detect = ipd_code(ipdSector, ipdAdvance);
    end

    // Supply samples taken while running
    if (supplySample && spinning) begin
      nxt_ff.supply = supplyAdc;
    end

    // Command from the active source
    unique case (cmdMode)
      SRC_PWM:    nxt_ff.cmd = pwmDuty;
      SRC_ANALOG: nxt_ff.cmd = analogLevel[9:2];
      default:    nxt_ff.cmd = cur_ff.ctrl[0][8:1];
    endcase

    // Other live readbacks
    nxt_ff.applied = appliedDuty;
    nxt_ff.analog  = analogLevel;
    nxt_ff.current = motorCurrent;
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign ctrlWords      = cur_ff.ctrl;
  assign eeWords        = cur_ff.ee;
  assign commandedSpeed = cur_ff.cmd;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_CTRL_WRITE: assert property (
    wrEvent && regIdx >= CTRL_FIRST && regIdx <= CTRL_LAST
    |=> ctrlWords[3'($past(regIdx) - CTRL_FIRST)] == $past(wrWord))
    else $error("control word not written");

  AST_EE_WRITE: assert property (
    wrEvent && regIdx >= EE_FIRST && regIdx <= EE_LAST
    |=> eeWords[3'($past(regIdx) - EE_FIRST)] == $past(wrWord))
    else $error("parameter word not written");

  AST_RO_HOLD: assert property (
    wrEvent && regIdx <= REG_IDS
    |=> $stable(ctrlWords) && $stable(eeWords))
    else $error("status write disturbed storage");

  AST_IPD_CODE: assert property (
    ipdDone |=> cur_ff.inductive_position_detect == $past(ipd_code(ipdSector, ipdAdvance)))
    else $error("position code wrong");

  AST_PERIOD: assert property (
    spinning && zeroCross |=> cur_ff.period == $past(cur_ff.pcnt))
    else $error("period not latched");

  AST_SPEED_DIV: assert property (
    cur_ff.divSt == DIV_IDLE && spinning && zeroCross
      && cur_ff.pcnt >= 16'h0010
    |-> ##21 (32'(cur_ff.speed) * 32'(cur_ff.dvsr) <= 32'(SPEED_NUM))
      && ((32'(cur_ff.speed) + 1) * 32'(cur_ff.dvsr) > 32'(SPEED_NUM)))
    else $error("speed quotient wrong");

  AST_KT: assert property (
    spinning && !zeroCross && cur_ff.halfOn && halfCross
    |=> cur_ff.kt == kt_scale($past(cur_ff.acc)))
    else $error("constant not stored");

  AST_SUPPLY: assert property (
    supplySample && spinning |=> cur_ff.supply == $past(supplyAdc))
    else $error("supply not sampled");

  AST_CMD_PWM: assert property (
    cmdMode == SRC_PWM |=> commandedSpeed == $past(pwmDuty))
    else $error("command not from duty input");

  AST_FAULT: assert property (
    ##1 cur_ff.fault[FB_OVER_TEMP] == $past(over_temperature_flag)
      && cur_ff.fault[FB_OVER_CURR] == $past(overCurrent)
      && cur_ff.fault[FB_LOCK_LO +: 6] == $past(lockedRotor))
    else $error("fault word stale");

  AST_SNAP: assert property (
    snapEvent |=> cur_ff.snap == $past(read_word(cur_ff, regIdx)))
    else $error("snapshot wrong");

  COV_WRITE: cover property (wrEvent);
  COV_SNAP: cover property (snapEvent ##[1:200] wrEvent);
  COV_SPEED: cover property (cur_ff.divSt == DIV_RUN ##20 !cur_ff.divSt);
  COV_IPD: cover property (ipdDone && ipdSector == 3'h5);

endmodule

// File: bench/i2c_host_model.sv
// Host side of the two-wire link: bit timing, start, stop, word access.
// Assumes a pulled-up data line; the target only ever pulls it low.
module i2c_host_model (
  // Serial pins
  output logic      sclClk,
  output logic      hostPullLow,
  input  wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [6:0] TARGET = 7'h52;

  ////////////////////////////////////////////////////////////////////////
  // Idle: clock parked high, data released
  initial begin
    sclClk = 1'b1;
    hostPullLow = 1'b0;
  end

  // One 6 ns bit; data set while clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic got);
    hostPullLow = !b;
    #1.5;
    sclClk = 1'b1;
    #1.5;
    got = sdaWire;
    #1.5;
    sclClk = 1'b0;
    #1.5;
  endtask

  // Eight bits high first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ackIn,
                         output logic [7:0] rx, output logic ackOut);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ackIn, ackOut);
  endtask

  // Data falls while clock high
  task automatic start_cond();
    hostPullLow = 1'b0;
    #1.5;
    sclClk = 1'b1;
    #1.5;
    hostPullLow = 1'b1;
    #1.5;
    sclClk = 1'b0;
    #1.5;
  endtask

  // Data rises while clock high, clock then stands high
  task automatic stop_cond();
    hostPullLow = 1'b1;
    #1.5;
    sclClk = 1'b1;
    #1.5;
    hostPullLow = 1'b0;
    #3;
  endtask

  // Word write; nack is high if any byte went unacknowledged
  task automatic write_word(input logic [6:0] addr, input logic [7:0] idx,
                            input logic [15:0] data, output logic nack);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    byte_io(idx, 1'b1, rx, a1);
    byte_io(data[15:8], 1'b1, rx, a2);
    byte_io(data[7:0], 1'b1, rx, a3);
    stop_cond();
    nack = a0 | a1 | a2 | a3;
  endtask

  // Word read; last byte left unacknowledged so the target lets go
  task automatic read_word(input logic [7:0] idx, output logic [15:0] data);
    logic a;
    start_cond();
    byte_io({TARGET, 1'b0}, 1'b1, data[7:0], a);
    byte_io(idx, 1'b1, data[7:0], a);
    #400;
    start_cond();
    byte_io({TARGET, 1'b1}, 1'b1, data[7:0], a);
    byte_io(8'hFF, 1'b0, data[15:8], a);
    byte_io(8'hFF, 1'b1, data[7:0], a);
    stop_cond();
  endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the readback bank and its two-wire port.
// Assumes the host model on the link; core clock 25 MHz.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk, rst, sclClk, hostPullLow, sdaOe;
  logic              over_temperature_flag, overCurrent, spinning, zeroCross, halfCross;
  logic              ipdDone, supplySample;
  logic [5:0]        lockedRotor;
  logic [7:0]        bemfLevel, supplyAdc, pwmDuty, appliedDuty;
  logic [7:0]        commandedSpeed;
  logic [10:0]       motorCurrent;
  logic [2:0]        ipdSector;
  logic [1:0]        ipdAdvance, cmdMode;
  logic [9:0]        analogLevel;
  logic [6:0][15:0]  ctrlWords, eeWords;
  logic [31:0]       seed;
  logic [15:0]       w, r, sw;
  logic [7:0]        idx, exp8;
  logic              nack;
  int                error_cnt, tests_run;
  wire               sdaWire = !(hostPullLow | sdaOe);

  ////////////////////////////////////////////////////////////////////////
  // Design and host
  motor_diag_readback #(.KT_SHIFT(1)) i_motor_diag_readback (
    .clk(clk), .rst(rst), .sclClk(sclClk), .sdaIn(sdaWire), .sdaOut(),
    .sdaOe(sdaOe), .over_temperature_flag(over_temperature_flag), .overCurrent(overCurrent),
    .lockedRotor(lockedRotor), .spinning(spinning), .zeroCross(zeroCross),
    .halfCross(halfCross), .bemfLevel(bemfLevel),
    .motorCurrent(motorCurrent), .ipdDone(ipdDone), .ipdSector(ipdSector),
    .ipdAdvance(ipdAdvance), .supplySample(supplySample),
    .supplyAdc(supplyAdc), .cmdMode(cmdMode), .pwmDuty(pwmDuty),
    .analogLevel(analogLevel), .appliedDuty(appliedDuty),
    .ctrlWords(ctrlWords), .eeWords(eeWords),
    .commandedSpeed(commandedSpeed));
  i2c_host_model i_i2c_host_model (
    .sclClk(sclClk), .hostPullLow(hostPullLow), .sdaWire(sdaWire));

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] ipd_exp(input int s, input int a);
    logic [7:0] pos [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};
    logic [7:0] adv [4] = '{8'h16, 8'h2C, 8'h3F, 8'h55};
    return pos[s] + adv[a];
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] i,
                    input logic [15:0] d);
    i_i2c_host_model.write_word(a, i, d, nack);
    step(10);
  endtask

  task automatic rd(input logic [7:0] i);
    i_i2c_host_model.read_word(i, r);
    step(10);
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  initial begin
    #3ms;
    error_cnt++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'hDBE1F4FD;
    {over_temperature_flag, overCurrent, spinning, zeroCross, halfCross} = '0;
    {ipdDone, supplySample, lockedRotor, bemfLevel, supplyAdc} = '0;
    {motorCurrent, ipdSector, ipdAdvance, cmdMode} = '0;
    {pwmDuty, analogLevel, appliedDuty} = '0;
    rst = 1'b1;
    step(12);
    rst <= 1'b0;
    chk({8'h00, commandedSpeed}, 16'h0000);
    step(4);
    // Control and parameter words, written then read back
    for (int i = 0; i < 14; i++) begin
      idx = (i < 7) ? 8'(8'h30 + i) : 8'(8'h90 + i - 7);
      w = 16'(rnd());
      wr(7'h52, idx, w);
      chk({15'h0, nack}, 16'h0000);
      chk((i < 7) ? ctrlWords[i] : eeWords[i - 7], w);
      rd(idx);
      chk(r, w);
    end
    // Foreign address is ignored, last parameter word keeps its value
    wr(7'h53, 8'h96, ~w);
    chk({15'h0, nack}, 16'h0001);
    chk(eeWords[6], w);
    // Fault word live, write to it ignored, unmapped reads zero
    for (int k = 0; k < 3; k++) begin
      w = 16'(rnd());
      over_temperature_flag <= w[0];
      overCurrent <= w[1];
      lockedRotor <= w[7:2];
      step(2);
      wr(7'h52, 8'h00, ~w);
      rd(8'h00);
      chk(r, {w[0], 3'h0, w[1], 5'h00, w[7:2]});
    end
    rd(8'h20);
    chk(r, 16'h0000);
    // Position sensing codes and supply samples
    spinning <= 1'b1;
    for (int s = 0; s < 6; s++) begin
      for (int a = 0; a < 4; a++) begin
        exp8 = 8'(rnd());
        ipdSector <= 3'(s);
        ipdAdvance <= 2'(a);
        supplyAdc <= exp8;
        {ipdDone, supplySample} <= 2'h3;
        step(1);
        {ipdDone, supplySample} <= 2'h0;
        step(3);
        rd(8'h05);
        chk(r, {ipd_exp(s, a), exp8});
      end
    end
    // Period 40 ticks, half cycle after 20 ticks, both tick-phase proof
    exp8 = 8'(rnd());
    bemfLevel <= exp8;
    zeroCross <= 1'b1;
    step(1);
    zeroCross <= 1'b0;
    step(5000);
    halfCross <= 1'b1;
    step(1);
    halfCross <= 1'b0;
    step(4999);
    zeroCross <= 1'b1;
    step(1);
    zeroCross <= 1'b0;
    step(30);
    rd(8'h02);
    chk(r, 16'h0028);
    rd(8'h01);
    chk(r, 16'(1000000 / 40));
    rd(8'h03);
    chk(r, 16'(20 * exp8) >> 1);
    // Speed command from every source
    sw = 16'(rnd());
    wr(7'h52, 8'h30, sw);
    for (int m = 0; m < 4; m++) begin
      w = 16'(rnd());
      cmdMode <= 2'(m);
      pwmDuty <= w[7:0];
      analogLevel <= w[9:0];
      appliedDuty <= w[15:8];
      motorCurrent <= w[10:0];
      step(4);
      exp8 = (m == 0) ? w[7:0] : (m == 1) ? w[9:2] : sw[8:1];
      chk({8'h00, commandedSpeed}, {8'h00, exp8});
      rd(8'h06);
      chk(r, {exp8, w[15:8]});
      rd(8'h04);
      chk(r, {5'h00, w[10:0]});
      rd(8'h07);
      chk(r, {6'h00, w[9:0]});
    end
    print_verdict();
  end
endmodule
